// *** design/wws_supervisor.sv ***
// wake pulse generator, watchdog monitor and reset supervisor
`timescale 1ns/1ps
`include "wws_cfg.svh"
module wws_supervisor
   import wws_pkg::*;
#(
   parameter int BASE_DIV = `WWS_BASE_DIV,
   parameter int RST_TICKS = `WWS_RST_TICKS,
   parameter int CNT_W = `WWS_CNT_W
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic enable,
   input wire logic out_in_regulation,
   input wire logic supply_input_ok,
   input wire logic watchdog_in,
   output logic wake_out,
   output logic reset_out_n,
   output logic regulator_on
);
   // derived tick counts
   localparam logic [CNT_W-1:0] RST_CNT = CNT_W'(RST_TICKS);
   // half period is half of eight reset delays; start delay is half a period
   localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(RST_TICKS * `WWS_PERIOD_MULT / 2);
   localparam logic [CNT_W-1:0] START_CNT = CNT_W'(RST_TICKS * `WWS_START_MULT);
   // one tick: the step of every phase counter and its final count
   localparam logic [CNT_W-1:0] ONE_CNT = CNT_W'(1);

   wws_state_type state_r;
   wws_state_type state_nxt;
   logic [CNT_W-1:0] cnt_r;        // base ticks left in current phase
   logic [CNT_W-1:0] cnt_nxt;
   logic seen_r;                   // edge accepted in this cycle
   logic seen_nxt;
   logic wake_r;
   logic wake_nxt;
   logic rstn_r;
   logic rstn_nxt;
   logic sync1_r;                  // first synchroniser stage
   logic sync2_r;                  // second synchroniser stage
   logic prev_r;                   // previous synchronised level
   logic wd_fall;                  // falling edge seen
   logic tick;                     // base tick enable
   logic run;                      // base running
   logic supply_bad;               // forced-reset cause: supply too low or output out of regulation

   // base counter held while shut down or in a forced reset; restarting it on
   // recovery means the reset delay is never cut short by a part-spent tick
   assign run = enable & (state_r != WWS_OFF) & (state_r != WWS_HOLD);
   wws_tick_div #(.DIV(BASE_DIV)) u_div
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .run(run),
      .tick(tick)
   );

   // synchroniser; only prev_r and sync2_r feed the edge detector
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         prev_r <= 1'b1;
      end
      else
      begin
         sync1_r <= watchdog_in;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   assign wd_fall = prev_r & ~sync2_r;

   // supply too low or output out of regulation forces reset at once
   assign supply_bad = ~supply_input_ok | ~out_in_regulation;

   // next state
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      seen_nxt = seen_r;
      wake_nxt = 1'b0;
      rstn_nxt = 1'b0;
      if (!enable)
      begin
         // shutdown: everything low and idle
         state_nxt = WWS_OFF;
      end
      else if (supply_bad)
      begin
         // hold reset while output or supply is bad
         state_nxt = WWS_HOLD;
      end
      else
      begin
         unique case (state_r)
            WWS_OFF, WWS_HOLD:
            begin
               // recovered: run the full reset delay from now
               state_nxt = WWS_DELAY;
               cnt_nxt = RST_CNT;
            end
            WWS_DELAY:
            begin
               if (tick)
               begin
                  if (cnt_r <= ONE_CNT)
                  begin
                     state_nxt = WWS_START;
                     cnt_nxt = START_CNT;
                     rstn_nxt = 1'b1;
                  end
                  else
                  begin
                     cnt_nxt = cnt_r - ONE_CNT;
                  end
               end
            end
            WWS_START:
            begin
               rstn_nxt = 1'b1;
               if (tick)
               begin
                  if (cnt_r <= ONE_CNT)
                  begin
                     state_nxt = WWS_WAKE_HI;
                     cnt_nxt = HALF_CNT;
                     seen_nxt = 1'b0;
                     wake_nxt = 1'b1;
                  end
                  else
                  begin
                     cnt_nxt = cnt_r - ONE_CNT;
                  end
               end
            end
            WWS_WAKE_HI, WWS_WAKE_LO:
            begin
               rstn_nxt = 1'b1;
               // first edge accepted, later ones ignored
               if (wd_fall && !seen_r)
               begin
                  seen_nxt = 1'b1;
               end
               // high half unless an edge was accepted
               wake_nxt = (state_r == WWS_WAKE_HI) && !seen_nxt;
               if (tick && cnt_r <= ONE_CNT)
               begin
                  if (state_r == WWS_WAKE_HI)
                  begin
                     state_nxt = WWS_WAKE_LO;
                     cnt_nxt = HALF_CNT;
                     wake_nxt = 1'b0;
                  end
                  else if (seen_nxt)
                  begin
                     state_nxt = WWS_WAKE_HI;
                     cnt_nxt = HALF_CNT;
                     seen_nxt = 1'b0;
                     wake_nxt = 1'b1;
                  end
                  else
                  begin
                     // missed watchdog: reset pulse one reset delay long
                     state_nxt = WWS_WD_PULSE;
                     cnt_nxt = RST_CNT;
                     rstn_nxt = 1'b0;
                  end
               end
               else if (tick)
               begin
                  cnt_nxt = cnt_r - ONE_CNT;
               end
            end
            WWS_WD_PULSE:
            begin
               // reset low, wake low, then restart via start delay
               if (tick)
               begin
                  if (cnt_r <= ONE_CNT)
                  begin
                     state_nxt = WWS_START;
                     cnt_nxt = START_CNT;
                     rstn_nxt = 1'b1;
                  end
                  else
                  begin
                     cnt_nxt = cnt_r - ONE_CNT;
                  end
               end
            end
         endcase
      end
   end

   // registers; reset low, wake low whenever reset low
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         state_r <= WWS_OFF;
         cnt_r <= '0;
         seen_r <= 1'b0;
         wake_r <= 1'b0;
         rstn_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         seen_r <= seen_nxt;
         wake_r <= wake_nxt & rstn_nxt;
         rstn_r <= rstn_nxt;
      end
   end

   assign wake_out = wake_r;
   assign reset_out_n = rstn_r;
   assign regulator_on = enable;
endmodule

// *** design/wws_tick_div.sv ***
// clock divider producing a one-cycle base tick enable
`timescale 1ns/1ps
`include "wws_cfg.svh"
module wws_tick_div
   import wws_pkg::*;
#(
   parameter int DIV = `WWS_BASE_DIV
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic run,
   output logic tick
);
   // divider count and its next value
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   // count down while running, reload on zero
   always_comb
   begin
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (!run)
      begin
         cnt_nxt = 32'(DIV - 1);
      end
      else if (cnt_r == 32'h0)
      begin
         cnt_nxt = 32'(DIV - 1);
         tick_nxt = 1'b1;
      end
      else
      begin
         cnt_nxt = cnt_r - 32'h1;
      end
   end

   // register only
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         cnt_r <= 32'h0;
         tick_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule

// *** dv/tb.sv ***
// self-checking bench for the wake/watchdog supervisor
`timescale 1ns/1ps
module tb;
   localparam int DIV = 100; // short base tick
   localparam int RD = 4 * DIV; // reset delay in clocks
   localparam int HALF = 4 * RD; // half period and start delay
   logic clk_sys, reset, enable, out_in_regulation, supply_input_ok, serve;
   logic watchdog_in, wake_out, reset_out_n, regulator_on;
   int errors, num_checks, n;
   wws_supervisor #(.BASE_DIV(DIV), .RST_TICKS(4)) DUT (.clk_sys(clk_sys), .reset(reset),
      .enable(enable), .out_in_regulation(out_in_regulation),
      .supply_input_ok(supply_input_ok), .watchdog_in(watchdog_in), .wake_out(wake_out),
      .reset_out_n(reset_out_n), .regulator_on(regulator_on));
   wws_mcu_model u_mcu (.clk_sys(clk_sys), .wake_out(wake_out), .serve(serve),
      .watchdog_in(watchdog_in));
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t: got %0d expected %0d", $time, got, exp);
      end
   endtask
   // cycles until wake (0), reset (1) or watchdog (2) reaches v
   task meas(input int i, input logic v);
      n = 0;
      while ((i == 2 ? watchdog_in : i ? reset_out_n : wake_out) !== v && n < 20000)
      begin
         @(negedge clk_sys);
         n++;
      end
      // a wait that runs out is a mismatch of its own
      if (n >= 20000)
      begin
         errors++;
         $display("ERROR %0t: wait limit reached", $time);
      end
   endtask
   function logic near(input int a, input int b, input int t);
      return a >= b - t && a <= b + t;
   endfunction
   task end_sim;
      if (errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // unserved cycle: start-up timing and the missed-edge reset
   task t_missed;
      meas(1, 1'b1);
      chk(near(n, RD, DIV + 2), 1'b1);
      meas(0, 1'b1);
      chk(near(n, HALF, DIV + 2), 1'b1);
      meas(0, 1'b0);
      chk(near(n, HALF, 2), 1'b1);
      meas(1, 1'b0);
      chk(near(n, HALF, 2), 1'b1);
      chk(wake_out, 1'b0);
      meas(1, 1'b1);
      chk(near(n, RD, DIV + 2), 1'b1);
   endtask
   // served cycle: wake dropped early, no reset follows
   task t_served;
      serve = 1'b1;
      meas(0, 1'b1);
      meas(2, 1'b0);
      meas(0, 1'b0);
      // edge seen one falling edge late; two sync stages plus the register
      chk(near(n, 2, 1), 1'b1);
      meas(0, 1'b1);
      chk(near(n, 2 * HALF - 504, DIV), 1'b1);
      chk(reset_out_n, 1'b1);
   endtask
   // low supply (1) or undervoltage (0) while wake is high
   task t_fault(input int k);
      meas(0, 1'b1);
      repeat (100) @(negedge clk_sys);
      if (k)
         supply_input_ok = 1'b0;
      else
         out_in_regulation = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk(reset_out_n, 1'b0);
      chk(wake_out, 1'b0);
      repeat (20) @(negedge clk_sys);
      supply_input_ok = 1'b1;
      out_in_regulation = 1'b1;
      meas(1, 1'b1);
      chk(near(n, RD, DIV + 2), 1'b1);
   endtask
   // enable passes straight to the regulator; shutdown resets, restart delays
   task t_enable;
      enable = 1'b0;
      #1;
      chk(regulator_on, 1'b0);
      repeat (2) @(negedge clk_sys);
      chk(reset_out_n, 1'b0);
      chk(wake_out, 1'b0);
      enable = 1'b1;
      #1;
      chk(regulator_on, 1'b1);
      meas(1, 1'b1);
      chk(near(n, RD, 3), 1'b1);
   endtask
   initial
   begin
      errors = 0;
      num_checks = 0;
      serve = 1'b0;
      reset = 1'b1;
      enable = 1'b1;
      out_in_regulation = 1'b1;
      supply_input_ok = 1'b1;
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      t_missed;
      t_served;
      t_fault(0);
      t_fault(1);
      t_enable;
      end_sim;
   end
   // hang guard, about three times the expected run
   initial
   begin
      #400000;
      errors++;
      end_sim;
   end
endmodule
bind wws_supervisor wws_checker #(.BASE_DIV(BASE_DIV), .RST_TICKS(RST_TICKS)) u_chk (
   .clk_sys(clk_sys), .reset(reset), .enable(enable), .out_in_regulation(out_in_regulation),
   .supply_input_ok(supply_input_ok), .watchdog_in(watchdog_in), .wake_out(wake_out),
   .reset_out_n(reset_out_n), .regulator_on(regulator_on));

// *** dv/wws_checker.sv ***
// concurrent checks on the supervisor ports
`timescale 1ns/1ps
`include "wws_cfg.svh"
module wws_checker
#(
   parameter int BASE_DIV = `WWS_BASE_DIV,
   parameter int RST_TICKS = `WWS_RST_TICKS
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic enable,
   input wire logic out_in_regulation,
   input wire logic supply_input_ok,
   input wire logic watchdog_in,
   input wire logic wake_out,
   input wire logic reset_out_n,
   input wire logic regulator_on
);
   localparam int RD = RST_TICKS * BASE_DIV; // reset delay in clocks
   localparam int HALF = (`WWS_PERIOD_MULT / 2) * RD; // half period and start delay
   // run lengths; 32 bits so the full-size default timing fits too
   logic [31:0] hi_r, hi_nxt, ok_r, ok_nxt, up_r, up_nxt;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   // saturating run counters, so a long run never wraps
   always_comb
   begin
      hi_nxt = 32'h0;
      ok_nxt = 32'h0;
      up_nxt = 32'h0;
      if (wake_out)
         hi_nxt = hi_r + {31'h0, hi_r != 32'hFFFFFFFF};
      if (enable && supply_input_ok && out_in_regulation)
         ok_nxt = ok_r + {31'h0, ok_r != 32'hFFFFFFFF};
      if (reset_out_n)
         up_nxt = up_r + {31'h0, up_r != 32'hFFFFFFFF};
   end
   // register the counters
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         hi_r <= 32'h0;
         ok_r <= 32'h0;
         up_r <= 32'h0;
      end
      else
      begin
         hi_r <= hi_nxt;
         ok_r <= ok_nxt;
         up_r <= up_nxt;
      end
   end
   a_wake_held_low: assert property (!reset_out_n |=> !wake_out)
      else $error("wake high during reset");
   a_supply_low_rst: assert property (!supply_input_ok |=> !reset_out_n)
      else $error("no reset on low supply");
   a_uv_rst: assert property (!out_in_regulation |=> !reset_out_n)
      else $error("no reset on undervoltage");
   a_reg_on_follow: assert property (regulator_on == enable)
      else $error("regulator state differs from enable");
   a_shutdown_rst: assert property (!enable |=> !reset_out_n && !wake_out)
      else $error("reset or wake active in shutdown");
   a_wd_drops_wake: assert property ($fell(watchdog_in) && wake_out |-> ##[3:5] !wake_out)
      else $error("wake not dropped by watchdog edge");
   a_low_stays: assert property ($fell(wake_out) |=> !wake_out[*8])
      else $error("wake rose again too soon");
   a_high_len: assert property (wake_out |-> hi_r <= 32'(HALF))
      else $error("wake high longer than half period");
   a_rst_delay: assert property ($rose(reset_out_n) |-> ok_r >= 32'(RD))
      else $error("reset released early");
   a_start_gap: assert property ($rose(wake_out) |-> up_r >= 32'(HALF))
      else $error("wake started too soon after reset");
   c_missed: cover property ($fell(reset_out_n) && supply_input_ok && out_in_regulation);
   c_served: cover property ($fell(watchdog_in) && wake_out);
   c_wake: cover property ($rose(wake_out));
endmodule

// *** dv/wws_mcu_model.sv ***
// controller stand-in: while serve is high, answers each wake rise with two watchdog pulses
`timescale 1ns/1ps
`include "wws_cfg.svh"
module wws_mcu_model
#(
   parameter int DLY = `WWS_WAKE_TO_WD_CYC
)
(
   input wire logic clk_sys,
   input wire logic wake_out,
   input wire logic serve,
   output logic watchdog_in
);
   logic wake_q; // wake level at the previous falling edge
   // one process owns the pin: idle high so only a deliberate fall counts;
   // the second pulse tests that extra edges are ignored
   initial
   begin
      watchdog_in = 1'b1;
      wake_q = 1'b0;
      forever
      begin
         @(negedge clk_sys);
         if (serve && wake_out && !wake_q)
         begin
            repeat (DLY) @(negedge clk_sys);
            for (int p = 0; p < 2; p++)
            begin
               watchdog_in <= 1'b0;
               repeat (50) @(negedge clk_sys);
               watchdog_in <= 1'b1;
               repeat (50) @(negedge clk_sys);
            end
         end
         wake_q = wake_out;
      end
   end
endmodule

// *** pkg/wws_cfg.svh ***
// timing constants and defaults for the wake/watchdog supervisor
`ifndef WWS_CFG_SVH
`define WWS_CFG_SVH
// clock rate in MHz
`define WWS_CLK_MHZ 100
// base tick divider: clock cycles per base tick (stands in for the resistor)
`define WWS_BASE_DIV 1000
// reset delay in base ticks; period is eight of these, start delay four
`define WWS_RST_TICKS 3125
`define WWS_PERIOD_MULT 8
`define WWS_START_MULT 4
// least time from wake rise to watchdog fall the partner keeps, in ns
`define WWS_WAKE_TO_WD_NS 5000
`define WWS_WAKE_TO_WD_CYC ((`WWS_WAKE_TO_WD_NS * `WWS_CLK_MHZ + 999) / 1000)
// width of the tick counters
`define WWS_CNT_W 20
`endif

// *** pkg/wws_pkg.sv ***
// types for the wake/watchdog supervisor
package wws_pkg;
   // supervisor states
   typedef enum logic [2:0]
   {
      WWS_OFF,
      WWS_HOLD,
      WWS_DELAY,
      WWS_START,
      WWS_WAKE_HI,
      WWS_WAKE_LO,
      WWS_WD_PULSE
   } wws_state_type;
endpackage
